//--- core/asram_ctrl.sv
/*
 * Controller that drives an asynchronous 16-bit static RAM through its pins.
 * Assumes the memory's data pins reach this clock through two flip-flops
 * here, and that the board resolves the data wire from data_oe.
 * Each phase lasts a whole number of clock cycles, so pin timing is only as
 * fine as the clock; a memory faster than the figures gains nothing here.
 */
// Function
// - Address stable 40 ns, write cycle 55 ns
// - Write pulse may start with address
// - Address unchanged until write ends
// - Lane enable active 40 ns before end
// - Data stable 25 ns before end, held
// - Write needs strobe, selects, a lane
// - Data timed from terminating edge
// - Wait 55 ns after retention exit
// - Retention may follow deselect at once
// - Write strobe inactive during reads
// - Never drive data while memory drives
`include "asram_map.svh"
`default_nettype none
module asram_ctrl
    import asram_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [`ASRAM_ADDR_W-1:0] req_addr,
    input wire logic [`ASRAM_DATA_W-1:0] req_wdata,
    input wire logic [1:0] req_lanes,
    output logic rsp_valid,
    output logic [`ASRAM_DATA_W-1:0] rsp_rdata,
    input wire logic retention_req,
    output logic retention_ok,
    output logic [`ASRAM_ADDR_W-1:0] mem_addr,
    output logic select_low_active_n,
    output logic select_high_active,
    output logic write_en_n,
    output logic out_gate_n,
    output logic upper_lane_en_n,
    output logic lower_lane_en_n,
    input wire logic [`ASRAM_DATA_W-1:0] data_in,
    output logic [`ASRAM_DATA_W-1:0] data_out,
    output logic data_oe
);
    asram_state_t state;
    asram_state_t next_state;
    logic [3:0] cnt;
    logic [`ASRAM_DATA_W-1:0] din_meta;
    logic [`ASRAM_DATA_W-1:0] din_sync;
    logic ret_meta;
    logic ret_sync;
    logic ret_seen;
    logic [1:0] lanes;

    // Cycle counts sized to the counter; each covers its ns minimum.
    localparam logic [3:0] READ_CYC = 4'(`ASRAM_READ_CYC);
    localparam logic [3:0] WPULSE_CYC = 4'(`ASRAM_WPULSE_CYC);
    localparam logic [3:0] WHOLD_CYC = 4'(`ASRAM_WCYC_CYC - `ASRAM_WPULSE_CYC);
    localparam logic [3:0] TURN_CYC = 4'(`ASRAM_TURN_CYC);
    localparam logic [3:0] REC_CYC = 4'(`ASRAM_RECOVER_CYC);

    function automatic logic [1:0] lanes_or_both(input logic [1:0] l);
        // An empty lane mask would deselect the memory, so use both lanes.
        lanes_or_both = (l == 2'b00) ? 2'b11 : l;
    endfunction : lanes_or_both

    // The memory is selected only in the read, write and write-hold phases.
    function automatic logic phase_selects(input asram_state_t s);
        phase_selects = (s == ASRAM_READ) || (s == ASRAM_WRITE) || (s == ASRAM_WHOLD);
    endfunction : phase_selects

    // Decode of phase completion and the idle accept condition.
    wire cnt_done = (cnt == 4'h1);
    wire in_idle = (state == ASRAM_IDLE);
    // A pending recovery also refuses requests: the idle cycle between the
    // synced retention exit and the recovery wait must not start an access.
    wire recover_due = ret_seen && !ret_sync;
    wire accept = in_idle && req_valid && !ret_sync && !ret_seen;
    assign req_ready = in_idle && !ret_sync && !ret_seen;
    assign retention_ok = in_idle && ret_sync;

    // Pin levels for the coming cycle, decoded once and registered below.
    wire pins_on = phase_selects(next_state);
    // The lane mask comes straight from the request in its accept cycle.
    wire [1:0] next_lanes = accept ? lanes_or_both(req_lanes) : lanes;

    // Memory data and the retention request come from outside this clock.
    // The data word is not gray coded; it is only used after it has stood
    // still for two cycles, so a torn sample cannot reach rsp_rdata.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            din_meta <= 16'h0000;
            din_sync <= 16'h0000;
            ret_meta <= 1'b0;
            ret_sync <= 1'b0;
        end else begin
            din_meta <= data_in;
            din_sync <= din_meta;
            ret_meta <= retention_req;
            ret_sync <= ret_meta;
        end
    end

    // Phase sequencing.
    // Reads end in a turn gap so the memory has let go of the wire first.
    always_comb begin
        next_state = state;
        case (state)
            ASRAM_IDLE: begin
                if (recover_due) begin
                    next_state = ASRAM_RECOVER;
                end else if (accept) begin
                    next_state = req_write ? ASRAM_WRITE : ASRAM_READ;
                end
            end
            ASRAM_READ: if (cnt_done) next_state = ASRAM_TURN;
            ASRAM_WRITE: if (cnt_done) next_state = ASRAM_WHOLD;
            ASRAM_WHOLD: if (cnt_done) next_state = ASRAM_IDLE;
            ASRAM_TURN: if (cnt_done) next_state = ASRAM_IDLE;
            ASRAM_RECOVER: if (cnt_done) next_state = ASRAM_IDLE;
            default: next_state = ASRAM_IDLE;
        endcase
    end

    // State, counter and latched request; counts stretch to whole cycles.
    // The count is loaded on entry, so a stale count never shortens a phase.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ASRAM_IDLE;
            cnt <= 4'h0;
            ret_seen <= 1'b0;
        end else begin
            state <= next_state;
            if (state != next_state) begin
                case (next_state)
                    ASRAM_READ: cnt <= READ_CYC;
                    ASRAM_WRITE: cnt <= WPULSE_CYC;
                    ASRAM_WHOLD: cnt <= WHOLD_CYC;
                    ASRAM_TURN: cnt <= TURN_CYC;
                    ASRAM_RECOVER: cnt <= REC_CYC;
                    default: cnt <= 4'h0;
                endcase
            end else if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end
            // Retention is remembered until the wait starts, so even a short pulse pays it.
            if (ret_sync) begin
                ret_seen <= 1'b1;
            end else if (state == ASRAM_RECOVER) begin
                ret_seen <= 1'b0;
            end
        end
    end

    // Address, lanes and write data held from acceptance to write end.
    // Holding them past the strobe keeps both steady at the terminating edge.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_addr <= 21'h00000;
            lanes <= 2'b00;
            data_out <= 16'h0000;
        end else if (accept) begin
            mem_addr <= req_addr;
            lanes <= lanes_or_both(req_lanes);
            data_out <= req_wdata;
        end
    end

    // Pin drive, registered so the pins never glitch.
    // Decoding from next_state keeps the registered pins in step with state, so no cycle of latency is added.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            select_low_active_n <= 1'b1;
            select_high_active <= 1'b0;
            write_en_n <= 1'b1;
            out_gate_n <= 1'b1;
            upper_lane_en_n <= 1'b1;
            lower_lane_en_n <= 1'b1;
            data_oe <= 1'b0;
        end else begin
            // Select and lanes stay on through the write hold, strobe ends first.
            select_low_active_n <= !pins_on;
            select_high_active <= pins_on;
            write_en_n <= (next_state != ASRAM_WRITE);
            out_gate_n <= (next_state != ASRAM_READ);
            lower_lane_en_n <= !(pins_on && next_lanes[0]);
            upper_lane_en_n <= !(pins_on && next_lanes[1]);
            // Drive data only in write phases; the turn gap keeps a read's
            // released lanes apart from the next write's drive.
            data_oe <= next_state inside {ASRAM_WRITE, ASRAM_WHOLD};
        end
    end

    // Read data is taken at the end of the turn gap; after the two sync
    // stages it is the word on the pins as the read phase closed, sixty ns
    // after the address, so the slow output path has settled by then.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 16'h0000;
        end else begin
            rsp_valid <= (state == ASRAM_TURN) && cnt_done;
            if ((state == ASRAM_TURN) && cnt_done) begin
                rsp_rdata <= din_sync;
            end
        end
    end
endmodule : asram_ctrl
`default_nettype wire

//--- core/asram_map.svh
/*
 * Timing figures and derived cycle counts for the async SRAM controller.
 * Assumes a 100 MHz core clock; nanosecond figures are as printed.
 */
`ifndef ASRAM_MAP_SVH
`define ASRAM_MAP_SVH
`define ASRAM_CLK_PERIOD_NS 10
`define ASRAM_READ_CYCLE_NS 55
`define ASRAM_OE_DATA_NS 25
`define ASRAM_WRITE_CYCLE_NS 55
`define ASRAM_WRITE_PULSE_NS 40
`define ASRAM_DATA_SETUP_NS 25
`define ASRAM_HZ_NS 18
`define ASRAM_RECOVERY_NS 55
// Least times round up to whole cycles.
`define ASRAM_CYC(ns) (((ns) + `ASRAM_CLK_PERIOD_NS - 1) / `ASRAM_CLK_PERIOD_NS)
`define ASRAM_READ_CYC `ASRAM_CYC(`ASRAM_READ_CYCLE_NS)
`define ASRAM_WPULSE_CYC `ASRAM_CYC(`ASRAM_WRITE_PULSE_NS)
`define ASRAM_WCYC_CYC `ASRAM_CYC(`ASRAM_WRITE_CYCLE_NS)
`define ASRAM_TURN_CYC `ASRAM_CYC(`ASRAM_HZ_NS)
`define ASRAM_RECOVER_CYC `ASRAM_CYC(`ASRAM_RECOVERY_NS)
`define ASRAM_ADDR_W 21
`define ASRAM_DATA_W 16
`endif

//--- core/asram_pkg.sv
/*
 * Types for the async SRAM controller.
 * Assumes asram_map.svh for widths.
 */
`default_nettype none
package asram_pkg;
    typedef enum logic [2:0] {
        ASRAM_IDLE = 3'b000,
        ASRAM_READ = 3'b001,
        ASRAM_WRITE = 3'b010,
        ASRAM_WHOLD = 3'b011,
        ASRAM_TURN = 3'b100,
        ASRAM_RECOVER = 3'b101
    } asram_state_t;
endpackage : asram_pkg
`default_nettype wire

//--- testbench/asram_ctrl_monitor.sv
/* Pin-timing checker for the async SRAM controller.
   Assumes it is bound to asram_ctrl with a 100 MHz core_clk. */
`include "asram_map.svh"
`default_nettype none
module asram_ctrl_monitor (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_write,
    input wire logic [1:0] req_lanes,
    input wire logic rsp_valid,
    input wire logic [`ASRAM_ADDR_W-1:0] mem_addr,
    input wire logic select_low_active_n,
    input wire logic select_high_active,
    input wire logic write_en_n,
    input wire logic out_gate_n,
    input wire logic upper_lane_en_n,
    input wire logic lower_lane_en_n,
    input wire logic [`ASRAM_DATA_W-1:0] data_out,
    input wire logic data_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // A 40 ns strobe at 10 ns per cycle is exactly four low cycles.
    sequence s_wpulse;
        (!write_en_n)[*4] ##1 write_en_n;
    endsequence
    sequence s_rphase;
        (!out_gate_n && $stable(mem_addr))[*5];
    endsequence
    AST_WE_PULSE: assert property ($fell(write_en_n) |-> s_wpulse)
        else $error("write strobe width wrong");
    AST_READ_HOLD: assert property ($fell(out_gate_n) |=> s_rphase)
        else $error("read phase too short");
    AST_WE_IN_READ: assert property (!out_gate_n |-> write_en_n)
        else $error("strobe low during read");
    AST_NO_CONTEND: assert property (data_oe |-> out_gate_n && $past(out_gate_n, 2))
        else $error("data driven near a read");
    AST_WRITE_SEL: assert property (!write_en_n |-> !select_low_active_n
        && select_high_active && !(upper_lane_en_n && lower_lane_en_n))
        else $error("write without selects");
    AST_ADDR_HOLD: assert property ($rose(write_en_n) |-> $past(mem_addr, 4) == mem_addr)
        else $error("address moved in write");
    AST_DATA_SETUP: assert property ($rose(write_en_n) |-> data_oe
        && $past(data_out, 3) == data_out ##1 data_oe)
        else $error("write data setup or hold");
    AST_LANE_MAP: assert property (req_valid && req_ready && req_lanes == 2'b01
        |=> upper_lane_en_n && !lower_lane_en_n)
        else $error("lane enable mapping");
    AST_READ_DONE: assert property (
        req_valid && req_ready && !req_write |-> ##[7:9] rsp_valid)
        else $error("read answer late");
endmodule : asram_ctrl_monitor
bind asram_ctrl asram_ctrl_monitor mon (.core_clk(core_clk), .arst_n(arst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_lanes(req_lanes), .rsp_valid(rsp_valid), .mem_addr(mem_addr),
    .select_low_active_n(select_low_active_n), .select_high_active(select_high_active),
    .write_en_n(write_en_n), .out_gate_n(out_gate_n), .upper_lane_en_n(upper_lane_en_n),
    .lower_lane_en_n(lower_lane_en_n), .data_out(data_out), .data_oe(data_oe));
`default_nettype wire

//--- testbench/asram_ctrl_tb.sv
/* Self-checking bench for the async SRAM controller.
   Assumes asram_model and the bound checker are compiled alongside. */
`default_nettype none
module asram_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 0, arst_n = 0, req_valid = 0, req_write = 0, retention_req = 0;
    logic [20:0] req_addr = 0;
    logic [15:0] req_wdata = 0;
    logic [15:0] shadow [4];
    logic [1:0] req_lanes = 0;
    logic [20:0] addrs [4] = '{21'h0, 21'h1fffff, 21'h0a5a5, 21'h12345};
    wire logic req_ready, rsp_valid, retention_ok, sl_n, sh, we_n, oe_n, ub_n, lb_n, data_oe;
    wire logic [15:0] rsp_rdata, data_out, dq;
    wire logic [20:0] mem_addr;
    int failures = 0, n_checks = 0;
    // The shared data wire: the controller wins only while it drives.
    wire logic [15:0] bus = data_oe ? data_out : dq;
    asram_ctrl dut (.core_clk(core_clk), .arst_n(arst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_lanes(req_lanes), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .retention_req(retention_req), .retention_ok(retention_ok),
        .mem_addr(mem_addr), .select_low_active_n(sl_n), .select_high_active(sh),
        .write_en_n(we_n), .out_gate_n(oe_n), .upper_lane_en_n(ub_n), .lower_lane_en_n(lb_n),
        .data_in(bus), .data_out(data_out), .data_oe(data_oe));
    asram_model mdl (.addr(mem_addr), .sel_n(sl_n), .sel(sh), .we_n(we_n), .oe_n(oe_n),
        .ub_n(ub_n), .lb_n(lb_n), .din(bus), .dq(dq));
    function automatic logic [15:0] lane_mask(input logic [1:0] l);
        return l == 2'b00 ? 16'hffff : {{8{l[1]}}, {8{l[0]}}};
    endfunction : lane_mask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    // Bounded wait on a level seen at the falling edge.
    task automatic wait_hi(input int which);
        int n;
        n = 0;
        while (!(which == 0 ? req_ready : which == 1 ? rsp_valid : retention_ok) && n < 50) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 50) begin
            failures++;
            finish_test();
        end
    endtask : wait_hi
    task automatic access(input logic w, input int i, input logic [15:0] d, input logic [1:0] l);
        req_write = w;
        req_addr = addrs[i];
        req_wdata = d;
        req_lanes = l;
        req_valid = 1;
        wait_hi(0);
        @(negedge core_clk);
        req_valid = 0;
        if (w) begin
            shadow[i] = (shadow[i] & ~lane_mask(l)) | (d & lane_mask(l));
            @(negedge core_clk); // Let an edge pass before req_valid may rise again.
        end else begin
            wait_hi(1);
            chk(rsp_rdata & lane_mask(l), shadow[i] & lane_mask(l));
        end
    endtask : access
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        int n;
        void'($urandom(32'h1b350356));
        repeat (20) @(negedge core_clk);
        arst_n = 1;
        foreach (addrs[i]) access(1, i, 16'($urandom), 2'b11);
        // Back-to-back write and read of the same word over every lane mask.
        for (int k = 0; k < 4; k++) begin
            access(1, 1, 16'($urandom), 2'(k));
            access(0, 1, 16'h0, 2'(3 - k));
        end
        repeat (40) access(1'($urandom), int'($urandom % 4), 16'($urandom), 2'($urandom));
        retention_req = 1;
        wait_hi(2);
        chk(16'(req_ready), 16'h0);
        retention_req = 0;
        n = 0;
        while (!req_ready && n < 50) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 50) begin
            failures++;
            finish_test();
        end
        chk(16'(n >= 6 && n < 50), 16'h1);
        access(0, 0, 16'h0, 2'b11);
        finish_test();
    end
endmodule : asram_ctrl_tb
`default_nettype wire

//--- testbench/asram_model.sv
/* Behavioural 16-bit async static RAM.
   Assumes the bench resolves the shared data wire into din. */
`default_nettype none
module asram_model (
    input wire logic [20:0] addr,
    input wire logic sel_n,
    input wire logic sel,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic ub_n,
    input wire logic lb_n,
    input wire logic [15:0] din,
    output logic [15:0] dq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [logic [20:0]];
    logic [15:0] look;
    logic lo_on = 1'b0;
    logic hi_on = 1'b0;
    wire act = !sel_n && sel && !(ub_n && lb_n);
    wire rd_lo = act && we_n && !oe_n && !lb_n;
    wire rd_hi = act && we_n && !oe_n && !ub_n;
    // Cells follow the data until the terminating edge ends the write.
    always @* begin
        if (act && !we_n && !lb_n) mem[addr][7:0] = din[7:0];
        if (act && !we_n && !ub_n) mem[addr][15:8] = din[15:8];
    end
    // Old data lingers 6 ns after an address move or a write.
    always @(addr, we_n) look <= #6 mem.exists(addr) ? mem[addr] : 16'h0;
    // Slow turn-on, quick turn-off, so hand-over never contends.
    always @(rd_lo) lo_on <= #(rd_lo ? 25 : 6) rd_lo;
    always @(rd_hi) hi_on <= #(rd_hi ? 25 : 6) rd_hi;
    // A released lane shows the inverse, not the last value.
    assign dq = {hi_on ? look[15:8] : ~look[15:8], lo_on ? look[7:0] : ~look[7:0]};
endmodule : asram_model
`default_nettype wire
